// ### common/fpr_consts.vh
`ifndef FPR_CONSTS_VH
`define FPR_CONSTS_VH
// crc32c, reflected form
`define FPR_CRC_INIT  32'hffffffff
`define FPR_CRC_POLY  32'h82f63b78
// digest bytes trailing each frame
`define FPR_CRC_BYTES 16'h0004
// five-field connection key width
`define FPR_TUPLE_W   104
`endif

// ### hw/fpr_crc32c_byte.v
`timescale 1ns/1ps
`default_nettype none
`include "fpr_consts.vh"

module fpr_crc32c_byte (
  input  wire [31:0] crc_in,
  input  wire [7:0]  data_in,
  output reg  [31:0] crc_out
);
  integer i;

  always @* begin
    crc_out = crc_in ^ {24'h000000, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      crc_out = crc_out[0] ? ((crc_out >> 1) ^ `FPR_CRC_POLY) : (crc_out >> 1);
    end
  end
endmodule // fpr_crc32c_byte

`default_nettype wire

// ### hw/fpr_receive_placement.v
`timescale 1ns/1ps
`default_nettype none
`include "fpr_consts.vh"

// Summary of operation
// - place only after ip/tcp ok and crc
// - match connection on five-field key
// - partial frames may span many segments
// - stored remaining count locates frame end
// - resume stored partial crc, then check
// - copy only when crc matches
// - copy local first part, then second part
// - save crc, count, buffer on split in-order frame
// - out-of-order: hold bytes, marker finds header
// - gap fill runs crc before held data
// - judge alignment on every segment
// - unaligned start uses stored connection state
// - aligned: length from payload start, check crc
// - repeat for every packed frame
// - fragmented datagrams are dropped by this block
// - digest is crc32c over header and payload
module fpr_receive_placement #(
  parameter NCONN = 4,
  parameter CW    = 2,
  parameter BW    = 8,
  parameter HAW   = 32
) (
  input  wire            ref_clk_in,
  input  wire            rst_in,
  input  wire            seg_valid_in,
  output wire            seg_ready_out,
  input  wire [31:0]     seg_src_ip_in,
  input  wire [31:0]     seg_dst_ip_in,
  input  wire [15:0]     seg_src_port_in,
  input  wire [15:0]     seg_dst_port_in,
  input  wire [7:0]      seg_proto_in,
  input  wire            seg_in_order_in,
  input  wire            seg_hdr_ok_in,
  input  wire            seg_ip_frag_in,
  input  wire [15:0]     seg_marker_off_in,
  input  wire [HAW-1:0]  seg_host_addr_in,
  input  wire            byte_valid_in,
  output wire            byte_ready_out,
  input  wire [7:0]      byte_data_in,
  input  wire            byte_last_in,
  output reg             host_copy_operation_valid_out,
  input  wire            host_copy_operation_ready_in,
  output reg             copy_from_local_out,
  output reg  [15:0]     copy_src_addr_out,
  output reg  [HAW-1:0]  copy_host_addr_out,
  output reg  [15:0]     copy_len_out,
  output reg             fpdu_done_out,
  output reg             crc_err_out,
  output reg             aligned_out,
  output reg             seg_drop_out
);
  localparam LW     = CW + 1 + BW;
  localparam S_IDLE = 4'h0;
  localparam S_LOOK = 4'h1;
  localparam S_HDR0 = 4'h2;
  localparam S_HDR1 = 4'h3;
  localparam S_BODY = 4'h4;
  localparam S_PL1  = 4'h5;
  localparam S_PL2  = 4'h6;
  localparam S_NXT  = 4'h7;
  localparam S_SKIP = 4'h8;
  localparam S_DRN  = 4'h9;

  reg  [3:0]                state;
  reg  [`FPR_TUPLE_W-1:0]   tup_q;
  reg                       ino_q;
  reg                       ok_q;
  reg                       frag_q;
  reg  [15:0]               moff_q;
  reg  [HAW-1:0]            hbase_q;
  reg  [NCONN-1:0]          used;
  reg  [CW-1:0]             alloc;
  reg  [`FPR_TUPLE_W-1:0]   tup    [0:NCONN-1];
  reg  [15:0]               rem_a  [0:NCONN-1];
  reg  [31:0]               pcrc_a [0:NCONN-1];
  reg  [31:0]               rxc_a  [0:NCONN-1];
  reg  [BW-1:0]             flen_a [0:NCONN-1];
  reg  [BW-1:0]             held_a [0:NCONN-1];
  reg  [HAW-1:0]            haddr_a[0:NCONN-1];
  reg  [7:0]                mem    [0:(1<<LW)-1];
  reg  [CW-1:0]             cidx;
  reg  [CW-1:0]             hit_idx;
  reg  [15:0]               cnt;
  reg  [15:0]               seg_off;
  reg  [15:0]               bstart;
  reg  [15:0]               bseg;
  reg  [31:0]               crc;
  reg  [31:0]               rxcrc;
  reg  [BW-1:0]             lptr;
  reg  [BW-1:0]             fst;
  reg  [BW-1:0]             rptr;
  reg  [BW-1:0]             hend;
  reg  [7:0]                lenhi;
  reg                       cont;
  reg                       replay;
  reg                       seg_end;
  reg  [HAW-1:0]            haddr;
  wire [NCONN-1:0]          hit_vec;
  wire                      hit;
  wire [7:0]                b;
  wire                      blast;
  wire                      step;
  wire [31:0]               crc_nx;
  wire [31:0]               rx_full;
  wire                      crc_ok;
  wire                      in_crc;
  wire [BW-1:0]             lptr_nx;
  wire [15:0]               rem_cur;
  wire [15:0]               len_fr;
  integer                   i;
  integer                   k;

  genvar g;
  generate
    for (g = 0; g < NCONN; g = g + 1) begin : g_cam
      assign hit_vec[g] = used[g] && (tup[g] == tup_q);
    end
  endgenerate

  always @* begin
    hit_idx = {CW{1'b0}};
    for (k = NCONN - 1; k >= 0; k = k - 1) begin
      if (hit_vec[k]) begin
        hit_idx = k[CW-1:0];
      end
    end
  end

  assign hit     = |hit_vec;
  assign rem_cur = hit ? rem_a[hit_idx] : 16'h0000;
  // held bytes replay from memory while the stream port stalls
  assign b       = replay ? mem[{cidx, 1'b1, rptr}] : byte_data_in;
  assign blast   = replay ? (rptr == hend - 1'b1) : byte_last_in;
  assign byte_ready_out = !replay && (state == S_HDR0 || state == S_HDR1 || state == S_BODY ||
                                      state == S_SKIP || state == S_DRN);
  assign step    = replay ? (state == S_BODY) : (byte_valid_in && byte_ready_out);
  assign seg_ready_out = (state == S_IDLE);
  assign rx_full = {rxcrc[23:0], b};
  assign crc_ok  = ((crc ^ `FPR_CRC_INIT) == rx_full);
  assign in_crc  = (cnt <= `FPR_CRC_BYTES);
  assign lptr_nx = lptr + 1'b1;
  assign len_fr  = {lenhi, b} + `FPR_CRC_BYTES;

  fpr_crc32c_byte u_crc (
    .crc_in  (crc),
    .data_in (b),
    .crc_out (crc_nx)
  );

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      used <= {NCONN{1'b0}};
      alloc <= {CW{1'b0}};
      for (i = 0; i < NCONN; i = i + 1) begin
        tup[i] <= {`FPR_TUPLE_W{1'b0}};
        rem_a[i] <= 16'h0000;
        pcrc_a[i] <= `FPR_CRC_INIT;
        rxc_a[i] <= 32'h00000000;
        flen_a[i] <= {BW{1'b0}};
        held_a[i] <= {BW{1'b0}};
        haddr_a[i] <= {HAW{1'b0}};
      end
      tup_q <= {`FPR_TUPLE_W{1'b0}};
      ino_q <= 1'b0;
      ok_q <= 1'b0;
      frag_q <= 1'b0;
      moff_q <= 16'h0000;
      hbase_q <= {HAW{1'b0}};
      cidx <= {CW{1'b0}};
      cnt <= 16'h0000;
      seg_off <= 16'h0000;
      bstart <= 16'h0000;
      bseg <= 16'h0000;
      crc <= `FPR_CRC_INIT;
      rxcrc <= 32'h00000000;
      lptr <= {BW{1'b0}};
      fst <= {BW{1'b0}};
      rptr <= {BW{1'b0}};
      hend <= {BW{1'b0}};
      lenhi <= 8'h00;
      cont <= 1'b0;
      replay <= 1'b0;
      seg_end <= 1'b0;
      haddr <= {HAW{1'b0}};
      host_copy_operation_valid_out <= 1'b0;
      copy_from_local_out <= 1'b0;
      copy_src_addr_out <= 16'h0000;
      copy_host_addr_out <= {HAW{1'b0}};
      copy_len_out <= 16'h0000;
      fpdu_done_out <= 1'b0;
      crc_err_out <= 1'b0;
      aligned_out <= 1'b0;
      seg_drop_out <= 1'b0;
    end else begin
      fpdu_done_out <= 1'b0;
      crc_err_out <= 1'b0;
      aligned_out <= 1'b0;
      seg_drop_out <= 1'b0;
      if (step && !replay) begin
        seg_off <= seg_off + 16'h0001;
      end
      case (state)
        S_IDLE: begin
          if (seg_valid_in) begin
            tup_q <= {seg_src_ip_in, seg_dst_ip_in, seg_src_port_in, seg_dst_port_in, seg_proto_in};
            ino_q <= seg_in_order_in;
            ok_q <= seg_hdr_ok_in;
            frag_q <= seg_ip_frag_in;
            moff_q <= seg_marker_off_in;
            hbase_q <= seg_host_addr_in;
            state <= S_LOOK;
          end
        end
        S_LOOK: begin
          cidx <= hit ? hit_idx : alloc;
          if (!hit) begin
            // unknown flow takes the next slot round robin, evicting its owner
            used[alloc] <= 1'b1;
            tup[alloc] <= tup_q;
            rem_a[alloc] <= 16'h0000;
            held_a[alloc] <= {BW{1'b0}};
            alloc <= alloc + 1'b1;
          end
          seg_off <= 16'h0000;
          replay <= 1'b0;
          cont <= 1'b0;
          crc <= `FPR_CRC_INIT;
          lptr <= {BW{1'b0}};
          fst <= {BW{1'b0}};
          bseg <= 16'h0000;
          bstart <= 16'h0000;
          haddr <= hbase_q;
          if (frag_q || !ok_q) begin
            seg_drop_out <= 1'b1;
            state <= S_DRN;
          end else if (ino_q && rem_cur != 16'h0000) begin
            cont <= 1'b1;
            cnt <= rem_cur;
            crc <= pcrc_a[hit_idx];
            rxcrc <= rxc_a[hit_idx];
            lptr <= flen_a[hit_idx];
            fst <= flen_a[hit_idx];
            haddr <= haddr_a[hit_idx];
            state <= S_BODY;
          end else if (ino_q || moff_q == 16'h0000) begin
            aligned_out <= 1'b1;
            state <= S_HDR0;
          end else begin
            state <= S_SKIP;
          end
        end
        S_HDR0: begin
          if (step) begin
            crc <= crc_nx;
            lenhi <= b;
            // a length field cut by the segment end is treated as lost alignment
            state <= blast ? S_IDLE : S_HDR1;
          end
        end
        S_HDR1: begin
          if (step) begin
            crc <= crc_nx;
            cnt <= len_fr;
            bstart <= seg_off + 16'h0001;
            bseg <= 16'h0000;
            if (blast) begin
              if (ino_q) begin
                rem_a[cidx] <= len_fr;
                pcrc_a[cidx] <= crc_nx;
                flen_a[cidx] <= {BW{1'b0}};
                haddr_a[cidx] <= haddr;
              end
              state <= S_IDLE;
            end else begin
              state <= S_BODY;
            end
          end
        end
        S_BODY: begin
          if (step) begin
            cnt <= cnt - 16'h0001;
            if (replay) begin
              rptr <= rptr + 1'b1;
            end
            if (!in_crc) begin
              crc <= crc_nx;
              bseg <= bseg + 16'h0001;
              if (!replay) begin
                // buffer size caps a split frame's first part; longer ones wrap
                mem[{cidx, 1'b0, lptr}] <= b;
                lptr <= lptr_nx;
              end
            end else begin
              rxcrc <= rx_full;
            end
            if (cnt == 16'h0001) begin
              fpdu_done_out <= 1'b1;
              crc_err_out <= !crc_ok;
              seg_end <= blast;
              if (cont) begin
                rem_a[cidx] <= 16'h0000;
              end
              copy_host_addr_out <= haddr;
              if (crc_ok) begin
                host_copy_operation_valid_out <= 1'b1;
                if (cont) begin
                  copy_from_local_out <= 1'b1;
                  copy_src_addr_out <= {{(16-LW){1'b0}}, cidx, 1'b0, {BW{1'b0}}};
                  copy_len_out <= {{(16-BW){1'b0}}, fst};
                  state <= S_PL1;
                end else begin
                  copy_from_local_out <= 1'b0;
                  copy_src_addr_out <= bstart;
                  copy_len_out <= bseg;
                  state <= S_PL2;
                end
              end else begin
                state <= S_NXT;
              end
            end else if (blast) begin
              if (ino_q) begin
                rem_a[cidx] <= cnt - 16'h0001;
                pcrc_a[cidx] <= in_crc ? crc : crc_nx;
                rxc_a[cidx] <= in_crc ? rx_full : rxcrc;
                flen_a[cidx] <= (!in_crc && !replay) ? lptr_nx : lptr;
                haddr_a[cidx] <= haddr;
              end
              if (!replay && ino_q && held_a[cidx] != {BW{1'b0}}) begin
                // gap filled: its bytes went first, now the held bytes follow
                replay <= 1'b1;
                rptr <= {BW{1'b0}};
                hend <= held_a[cidx];
                held_a[cidx] <= {BW{1'b0}};
                cont <= 1'b1;
                fst <= in_crc ? lptr : lptr_nx;
                bseg <= 16'h0000;
              end else begin
                replay <= 1'b0;
                state <= S_IDLE;
              end
            end
          end
        end
        S_PL1: begin
          if (host_copy_operation_ready_in) begin
            copy_from_local_out <= replay;
            copy_src_addr_out <= replay ? {{(16-LW){1'b0}}, cidx, 1'b1, {BW{1'b0}}} : bstart;
            copy_host_addr_out <= haddr + {{(HAW-BW){1'b0}}, fst};
            copy_len_out <= bseg;
            state <= S_PL2;
          end
        end
        S_PL2: begin
          if (host_copy_operation_ready_in) begin
            host_copy_operation_valid_out <= 1'b0;
            state <= S_NXT;
          end
        end
        S_NXT: begin
          haddr <= haddr + {{(HAW-BW){1'b0}}, fst} + {{(HAW-16){1'b0}}, bseg};
          if (seg_end || replay) begin
            replay <= 1'b0;
            state <= S_IDLE;
          end else begin
            crc <= `FPR_CRC_INIT;
            lptr <= {BW{1'b0}};
            fst <= {BW{1'b0}};
            cont <= 1'b0;
            state <= S_HDR0;
          end
        end
        S_SKIP: begin
          if (step) begin
            mem[{cidx, 1'b1, lptr}] <= b;
            lptr <= lptr_nx;
            if (seg_off + 16'h0001 == moff_q) begin
              held_a[cidx] <= lptr_nx;
              lptr <= {BW{1'b0}};
              state <= blast ? S_IDLE : S_HDR0;
            end else if (blast) begin
              held_a[cidx] <= lptr_nx;
              state <= S_IDLE;
            end
          end
        end
        S_DRN: begin
          if (step && blast) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fpr_receive_placement

`default_nettype wire

// ### tb/fpr_sender.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpr_consts.vh"
module fpr_sender (
  input  wire logic         clk_in,
  input  wire logic         seg_ready_in,
  input  wire logic         byte_ready_in,
  output var  logic         seg_valid_out,
  output var  logic [103:0] key_out,
  output var  logic [2:0]   flags_out,
  output var  logic [31:0]  host_addr_out,
  output var  logic         byte_valid_out,
  output var  logic [7:0]   byte_data_out,
  output var  logic         byte_last_out
);
  logic [7:0] q[$];
  initial begin
    seg_valid_out = 1'b0;
    key_out = 104'h0;
    flags_out = 3'h0;
    host_addr_out = 32'h0;
    byte_valid_out = 1'b0;
    byte_data_out = 8'h0;
    byte_last_out = 1'b0;
  end
  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ `FPR_CRC_POLY) : (c >> 1);
    return c;
  endfunction
  // whole frames only; send_seg may cut one across segments
  task automatic add_frame(input int n, input logic [7:0] s, input logic bad);
    logic [31:0] c;
    logic [7:0]  f[$];
    f = {n[15:8], n[7:0]};
    for (int i = 0; i < n; i++)
      f.push_back(s + i[7:0]);
    c = `FPR_CRC_INIT;
    foreach (f[i])
      c = crc_b(c, f[i]);
    c = ~c ^ {31'h0, bad};
    q = {q, f, c[31:24], c[23:16], c[15:8], c[7:0]};
  endtask
  task automatic send_seg(input int n, input logic [103:0] k, input logic [2:0] fl, input logic [31:0] ha);
    @(negedge clk_in);
    seg_valid_out = 1'b1;
    key_out = k;
    flags_out = fl;
    host_addr_out = ha;
    while (!seg_ready_in) @(negedge clk_in);
    @(negedge clk_in);
    seg_valid_out = 1'b0;
    key_out = ~k;
    for (int i = 0; i < n; i++) begin
      byte_valid_out = 1'b1;
      byte_data_out = q.pop_front();
      byte_last_out = (i == n - 1);
      while (!byte_ready_in) @(negedge clk_in);
      @(negedge clk_in);
    end
    // released line shows garbage, not the last byte
    byte_valid_out = 1'b0;
    byte_data_out = ~byte_data_out;
    byte_last_out = 1'b0;
  endtask
endmodule // fpr_sender
`default_nettype wire

// ### tb/fpr_receive_placement_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fpr_rp_checker #(parameter HAW = 32) (
  input wire logic           ref_clk_in,
  input wire logic           rst_in,
  input wire logic           seg_valid_in,
  input wire logic           seg_ready_out,
  input wire logic           seg_ip_frag_in,
  input wire logic           byte_ready_out,
  input wire logic           host_copy_operation_valid_out,
  input wire logic           host_copy_operation_ready_in,
  input wire logic           copy_from_local_out,
  input wire logic [15:0]    copy_len_out,
  input wire logic [HAW-1:0] copy_host_addr_out,
  input wire logic           fpdu_done_out,
  input wire logic           crc_err_out,
  input wire logic           aligned_out,
  input wire logic           seg_drop_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire take = seg_valid_in && seg_ready_out;
  wire cv = host_copy_operation_valid_out;
  // set once the local first part of a pair is accepted; held parts are local too
  logic second;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      second <= 1'b0;
    end else if (cv && host_copy_operation_ready_in) begin
      second <= !second && copy_from_local_out;
    end
  end
  property p_err_done; crc_err_out |-> fpdu_done_out && !cv; endproperty
  a_err_done: assert property (p_err_done) else $error("crc error without done or with copy");
  property p_good_copy; fpdu_done_out && !crc_err_out |-> cv; endproperty
  a_good_copy: assert property (p_good_copy) else $error("good frame not copied");
  property p_copy_hold;
    cv && !host_copy_operation_ready_in |=> cv && $stable(copy_len_out) && $stable(copy_host_addr_out)
      && $stable(copy_from_local_out);
  endproperty
  a_copy_hold: assert property (p_copy_hold) else $error("copy request changed while stalled");
  property p_refuse; take |=> !seg_ready_out [*2]; endproperty
  a_refuse: assert property (p_refuse) else $error("descriptor taken while busy");
  property p_answer; take |-> ##2 (byte_ready_out || seg_drop_out); endproperty
  a_answer: assert property (p_answer) else $error("no answer two cycles after descriptor");
  property p_frag; take && seg_ip_frag_in |-> ##2 seg_drop_out; endproperty
  a_frag: assert property (p_frag) else $error("fragment not dropped");
  property p_done_pulse; fpdu_done_out |=> !fpdu_done_out; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_align_pulse; aligned_out |=> !aligned_out; endproperty
  a_align_pulse: assert property (p_align_pulse) else $error("aligned longer than one cycle");
  property p_local_first; cv && host_copy_operation_ready_in && copy_from_local_out && !second |=> cv; endproperty
  a_local_first: assert property (p_local_first) else $error("second part copy missing");
  property p_drop_quiet; seg_drop_out |-> !cv && !fpdu_done_out; endproperty
  a_drop_quiet: assert property (p_drop_quiet) else $error("dropped segment placed");
endmodule // fpr_rp_checker
bind fpr_receive_placement fpr_rp_checker #(.HAW(HAW)) fpr_rp_checker_inst (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .seg_valid_in(seg_valid_in), .seg_ready_out(seg_ready_out), .seg_ip_frag_in(seg_ip_frag_in),
  .byte_ready_out(byte_ready_out), .host_copy_operation_valid_out(host_copy_operation_valid_out),
  .host_copy_operation_ready_in(host_copy_operation_ready_in), .copy_from_local_out(copy_from_local_out),
  .copy_len_out(copy_len_out), .copy_host_addr_out(copy_host_addr_out), .fpdu_done_out(fpdu_done_out),
  .crc_err_out(crc_err_out), .aligned_out(aligned_out), .seg_drop_out(seg_drop_out));
`default_nettype wire

// ### tb/fpr_receive_placement_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fpr_receive_placement_bench;
  localparam logic [103:0] KA = 104'h0a000001_0a000002_1000_2000_06;
  localparam logic [103:0] KB = 104'h0a000003_0a000002_1001_2000_06;
  localparam logic [103:0] KC = 104'h0a000004_0a000002_1002_2000_06;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         hrdy = 1'b0;
  logic         sv, srdy, bv, brdy, bl, cv, loc, done, err, al, drop;
  logic [103:0] key;
  logic [2:0]   fl;
  logic [31:0]  ha, caddr;
  logic [7:0]   bd;
  logic [15:0]  clen, csrc;
  logic [15:0]  moff = 16'h0000;
  logic [64:0]  cq[$];
  logic [15:0]  n_done, n_err, n_al, n_drop;
  int           cycles = 0;
  int           num_errors = 0;
  int           samples_checked = 0;
  fpr_sender fpr_sender_inst (.clk_in(clk), .seg_ready_in(srdy), .byte_ready_in(brdy), .seg_valid_out(sv),
    .key_out(key), .flags_out(fl), .host_addr_out(ha), .byte_valid_out(bv), .byte_data_out(bd),
    .byte_last_out(bl));
  fpr_receive_placement fpr_receive_placement_inst (.ref_clk_in(clk), .rst_in(rst), .seg_valid_in(sv),
    .seg_ready_out(srdy), .seg_src_ip_in(key[103:72]), .seg_dst_ip_in(key[71:40]),
    .seg_src_port_in(key[39:24]), .seg_dst_port_in(key[23:8]), .seg_proto_in(key[7:0]),
    .seg_in_order_in(fl[2]), .seg_hdr_ok_in(fl[1]), .seg_ip_frag_in(fl[0]), .seg_marker_off_in(moff),
    .seg_host_addr_in(ha), .byte_valid_in(bv), .byte_ready_out(brdy), .byte_data_in(bd), .byte_last_in(bl),
    .host_copy_operation_valid_out(cv), .host_copy_operation_ready_in(hrdy), .copy_from_local_out(loc),
    .copy_src_addr_out(csrc), .copy_host_addr_out(caddr), .copy_len_out(clen), .fpdu_done_out(done),
    .crc_err_out(err), .aligned_out(al), .seg_drop_out(drop));
  initial forever #5 clk = ~clk;
  // host side stalls every other cycle
  always @(negedge clk) hrdy <= ~hrdy;
  always @(posedge clk) begin
    if (!rst) begin
      if (cv && hrdy)
        cq.push_back({csrc, loc, clen, caddr});
      n_done += done;
      n_err += err;
      n_al += al;
      n_drop += drop;
    end
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [64:0] s, input logic [64:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic clr;
    cq = {};
    n_done = 0;
    n_err = 0;
    n_al = 0;
    n_drop = 0;
  endtask
  task automatic idle;
    @(negedge clk);
    while (!srdy || cv) @(negedge clk);
  endtask
  task automatic t_aligned;
    clr();
    fpr_sender_inst.add_frame(2, 8'h10, 1'b0);
    fpr_sender_inst.add_frame(3, 8'h20, 1'b0);
    fpr_sender_inst.send_seg(17, KA, 3'b110, 32'h1000);
    idle();
    chk("aligned", n_al, 1);
    chk("done", n_done, 2);
    chk("copies", cq.size(), 2);
    chk("copy0", cq[0], {16'h0002, 1'b0, 16'h0002, 32'h00001000});
    chk("copy1", cq[1], {16'h000a, 1'b0, 16'h0003, 32'h00001002});
    $display("test aligned packed finished");
  endtask
  task automatic t_bad;
    clr();
    fpr_sender_inst.add_frame(5, 8'h30, 1'b1);
    fpr_sender_inst.send_seg(11, KA, 3'b010, 32'h1100);
    idle();
    chk("bad aligned", n_al, 1);
    chk("bad done", n_done, 1);
    chk("bad err", n_err, 1);
    chk("bad copies", cq.size(), 0);
    $display("test bad digest finished");
  endtask
  task automatic t_frag;
    clr();
    fpr_sender_inst.add_frame(1, 8'h40, 1'b0);
    fpr_sender_inst.send_seg(7, KA, 3'b111, 32'h1200);
    idle();
    chk("frag drop", n_drop, 1);
    chk("frag copies", cq.size() + n_done, 0);
    $display("test fragment finished");
  endtask
  task automatic t_split;
    logic [7:0] rest[$];
    clr();
    fpr_sender_inst.add_frame(4, 8'h50, 1'b0);
    fpr_sender_inst.send_seg(4, KA, 3'b110, 32'h00002000);
    idle();
    chk("split early", cq.size() + n_done, 0);
    // other connection in between must not disturb the stored state
    rest = fpr_sender_inst.q;
    fpr_sender_inst.q = {};
    fpr_sender_inst.add_frame(1, 8'h60, 1'b0);
    fpr_sender_inst.send_seg(7, KB, 3'b110, 32'h00003000);
    idle();
    chk("other copy", cq[0], {16'h0002, 1'b0, 16'h0001, 32'h00003000});
    clr();
    fpr_sender_inst.q = rest;
    fpr_sender_inst.send_seg(6, KA, 3'b110, 32'h00002000);
    idle();
    chk("split aligned", n_al, 0);
    chk("split done", n_done, 1);
    chk("split copies", cq.size(), 2);
    chk("split part1", cq[0][48:0], {1'b1, 16'h0002, 32'h00002000});
    chk("split part2", cq[1], {16'h0000, 1'b0, 16'h0002, 32'h00002002});
    $display("test split frame finished");
  endtask
  task automatic t_ooo;
    logic [7:0] head[$];
    clr();
    fpr_sender_inst.add_frame(4, 8'ha0, 1'b0);
    repeat (5) head.push_back(fpr_sender_inst.q.pop_front());
    fpr_sender_inst.add_frame(1, 8'hb0, 1'b0);
    // later segment first: tail of the open frame, then a whole frame at the marker
    moff = 16'h0005;
    fpr_sender_inst.send_seg(12, KC, 3'b010, 32'h00005000);
    idle();
    moff = 16'h0000;
    chk("ooo aligned", n_al, 0);
    chk("ooo done", n_done, 1);
    chk("ooo copy", cq[0], {16'h0007, 1'b0, 16'h0001, 32'h00005000});
    clr();
    fpr_sender_inst.q = head;
    fpr_sender_inst.send_seg(5, KC, 3'b110, 32'h00004000);
    idle();
    chk("gap done", n_done, 1);
    chk("gap err", n_err, 0);
    chk("gap copies", cq.size(), 2);
    chk("gap part1", cq[0][48:0], {1'b1, 16'h0003, 32'h00004000});
    chk("gap part2", cq[1][48:0], {1'b1, 16'h0001, 32'h00004003});
    clr();
    fpr_sender_inst.add_frame(1, 8'hb0, 1'b0);
    fpr_sender_inst.send_seg(7, KC, 3'b010, 32'h00005000);
    idle();
    chk("resend copy", cq[0], {16'h0002, 1'b0, 16'h0001, 32'h00005000});
    $display("test out of order finished");
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_aligned();
    t_bad();
    t_frag();
    t_split();
    t_ooo();
    conclude();
  end
endmodule // fpr_receive_placement_bench
`default_nettype wire
